// *** src/tcc_consts.svh ***
// What this block does
// - Sensitivity is one plus linear and quadratic terms of T minus reference; scales Hall.
// - Linear code is 9 bits; coefficient is (code-160)/65536 per degree.
// - Quadratic code is 8 bits; coefficient is (code-128)/8388608 per degree squared.
// - Reference temperature code is 3 bits; value is 16 times code minus 48.
// - User coefficient settings add to factory values instead of replacing them.
// - Processing is deterministic; same inputs and settings give the same output.
// - All setup bits go to working RAM; the block runs from RAM.
// - Hall converter values can be read out; a test mode passes raw samples.
// - With both freeze bits set, memory is frozen and the link is disabled.
// - Each protected row holds an odd count of ones, parity included.
// - Ones in even bit positions over all lines total an even count.
// - Ones in odd bit positions over all lines total an odd count.
// - Row and column parity locate and correct any single-bit error.
// - An uncorrectable error forces the output to the supply-level error code.
// - Array holds 135 calibration bits plus 25 parity bits.
// - Data passes both ways over the supply and output pin link.
//
// Purpose: constants of the compensation and calibration memory block
// Assumes: 40 MHz clock, 16 lines of 10 bits, bit 9 of a line is row parity
// Notes:   line 15 is the column parity line and has no row parity
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH
`define TCC_LINES       16
`define TCC_COLS        10
`define TCC_DATA_LINES  15
`define TCC_NVM_BLANK   {10'h0aa, {15{10'h200}}}
`define TCC_L_LIN       4'h0
`define TCC_L_QUAD      4'h1
`define TCC_L_REF       4'h2
`define TCC_L_LIN_F     4'hc
`define TCC_L_QUAD_F    4'hd
`define TCC_L_REF_F     4'he
`define TCC_L_LOCK      4'he
`define TCC_B_LOCK0     7
`define TCC_B_LOCK1     8
`define TCC_B_TEST      8
`define TCC_LIN_OFS     11'sh0a0
`define TCC_QUAD_OFS    10'sh080
`define TCC_REF_OFS     11'sh030
`define TCC_LIN_SHIFT   7
`define TCC_FRAC        23
`define TCC_ONE         36'sh000800000
`define TCC_ERR_CODE    16'sh7fff
`define TCC_SAT_LO      16'sh8000
`define TCC_F_WR        23
`define TCC_F_NVM       22
`define TCC_F_ADDR      21:16
`define TCC_F_LAST      5'h17
`define TCC_R_LAST      5'h0f
`define TCC_A_NVM       6'h10
`define TCC_A_HALL      6'h20
`define TCC_A_STATUS    6'h21
`define TCC_CLK_NS      25
`define TCC_ERASE_MS    80
`define TCC_WRITE_MS    10
`define TCC_PROG_CYC    ((`TCC_ERASE_MS + `TCC_WRITE_MS) * 1000000 / `TCC_CLK_NS)
`define TCC_PROG_W      22
`define TCC_IDLE_US     100
`define TCC_IDLE_CYC    (`TCC_IDLE_US * 1000 / `TCC_CLK_NS)
`endif

// *** src/tcc_pkg.sv ***
// Purpose: shared types of the compensation block
// Assumes: constants header on the include path
// Notes:   memory is packed line by line, line 0 lowest
`include "tcc_consts.svh"
package tcc_pkg;
  typedef logic [`TCC_LINES-1:0][`TCC_COLS-1:0] tcc_mem_t;
  typedef logic signed [15:0]                   tcc_hall_t;
  typedef logic signed [8:0]                    tcc_temp_t;
  typedef enum logic [1:0] {LK_SHIFT, LK_REPLY, LK_PROG} tcc_link_st_t;
endpackage

// *** src/tcc_ecc.sv ***
// Purpose: matrix parity check and single-bit correction of the array
// Assumes: lines 0..14 carry odd row parity in bit 9, line 15 is column parity
// Notes:   purely combinational, flags any syndrome other than one bad column with at most one bad row
`timescale 1ns/1ps
`include "tcc_consts.svh"
module tcc_ecc (
  input  wire tcc_pkg::tcc_mem_t raw_in,
  output tcc_pkg::tcc_mem_t      corr_out,
  output logic                   corrected_out,
  output logic                   uncorr_out
);
  import tcc_pkg::*;

  logic [`TCC_LINES-1:0] row_bad;
  logic [`TCC_COLS-1:0]  col_bad;

  // ----------------------------------------
  // Syndromes
  // ----------------------------------------
  // Row checks on lines 0..14 only, one column check per column
  for (genvar g = 0; g < `TCC_LINES; g++) begin : g_row
    if (g < `TCC_DATA_LINES) begin : g_chk
      assign row_bad[g] = ~(^raw_in[g]);
    end else begin : g_free
      assign row_bad[g] = 1'b0;
    end
  end
  for (genvar c = 0; c < `TCC_COLS; c++) begin : g_col
    logic [`TCC_LINES-1:0] col;
    for (genvar r = 0; r < `TCC_LINES; r++) begin : g_bit
      assign col[r] = raw_in[r][c];
    end
    // Even columns want even count, odd columns odd
    assign col_bad[c] = (^col) ^ ((c % 2) == 1);
  end

  // ----------------------------------------
  // Correction
  // ----------------------------------------
  // One bad column plus at most one bad row pins a single bit
  always_comb begin
    corr_out      = raw_in;
    corrected_out = 1'b0;
    uncorr_out    = 1'b0;
    if (col_bad == '0 && row_bad == '0) begin
      corrected_out = 1'b0;
    end else if ($onehot(col_bad) && $onehot0(row_bad)) begin
      corrected_out = 1'b1;
      for (int r = 0; r < `TCC_LINES; r++) begin
        for (int c = 0; c < `TCC_COLS; c++) begin
          if (col_bad[c] && (row_bad[r] || (row_bad == '0 && r == `TCC_LINES - 1))) begin
            corr_out[r][c] = ~raw_in[r][c];
          end
        end
      end
    end else begin
      uncorr_out = 1'b1;
    end
  end
endmodule

// *** src/tcc_top.sv ***
// Purpose: temperature compensation and calibration memory of a Hall sensor
// Assumes: supply-pin clock and output-pin level arrive already digitised
// Notes:   array is modelled in flip-flops; reset restores the blank image
`timescale 1ns/1ps
`include "tcc_consts.svh"
module tcc_top #(
  parameter int unsigned PROG_CYC = `TCC_PROG_CYC
) (
  input  wire logic              clock_in,
  input  wire logic              rst_n_in,
  input  wire logic              vdd_clk_in,
  input  wire logic              link_pin_in,
  output logic                   link_pin_out,
  output logic                   link_pin_oe_out,
  input  wire tcc_pkg::tcc_temp_t temp_in,
  input  wire tcc_pkg::tcc_hall_t hall_in,
  input  wire logic              hall_valid_in,
  output tcc_pkg::tcc_hall_t     comp_out,
  output logic                   comp_valid_out,
  output logic                   ecc_error_out,
  output logic                   locked_out,
  output logic                   prog_busy_out
);
  import tcc_pkg::*;

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic vdd_s1;
  logic vdd_s2;
  logic vdd_d;
  logic pin_s1;
  logic pin_s2;
  logic rise;

  // Both pins are asynchronous to clock_in
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      vdd_s1 <= 1'b0;
      vdd_s2 <= 1'b0;
      vdd_d  <= 1'b0;
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
    end else begin
      vdd_s1 <= vdd_clk_in;
      vdd_s2 <= vdd_s1;
      vdd_d  <= vdd_s2;
      pin_s1 <= link_pin_in;
      pin_s2 <= pin_s1;
    end
  end

  // Edge detect reads the second stage and its delayed copy, never the first stage
  assign rise = vdd_s2 & ~vdd_d;

  // ----------------------------------------
  // Memory and error correction
  // ----------------------------------------
  tcc_mem_t ram;
  tcc_mem_t nvm;
  tcc_mem_t corr;
  logic     corrected;
  logic     uncorr;
  logic     boot;
  logic     locked;

  // 16 x 10 bits: 135 data plus 25 parity
  tcc_ecc u_ecc (
    .raw_in        (nvm),
    .corr_out      (corr),
    .corrected_out (corrected),
    .uncorr_out    (uncorr)
  );

  // Freeze needs both redundant bits, so one flip cannot lock
  assign locked = corr[`TCC_L_LOCK][`TCC_B_LOCK0] & corr[`TCC_L_LOCK][`TCC_B_LOCK1];

  // ----------------------------------------
  // Link framing
  // ----------------------------------------
  tcc_link_st_t          state;
  logic [4:0]            bit_cnt;
  logic [22:0]           shreg;
  logic [23:0]           frame;
  logic [15:0]           reply;
  logic [11:0]           idle_cnt;
  logic [`TCC_PROG_W-1:0] prog_cnt;
  logic                  idle_to;
  logic                  frame_end;
  logic                  frame_ok;
  logic                  wr_ram;
  logic                  prog_go;
  logic                  read_go;
  logic                  prog_done;
  logic [5:0]            addr;

  assign frame     = {shreg, pin_s2};
  assign addr      = frame[`TCC_F_ADDR];
  assign idle_to   = (idle_cnt == 12'(`TCC_IDLE_CYC - 1));
  assign frame_end = rise && (state == LK_SHIFT) && (bit_cnt == `TCC_F_LAST);
  // Frozen part drops every frame
  assign frame_ok  = frame_end && !locked;
  assign wr_ram    = frame_ok && frame[`TCC_F_WR] && !frame[`TCC_F_NVM] && (addr < `TCC_A_NVM);
  assign prog_go   = frame_ok && frame[`TCC_F_WR] && frame[`TCC_F_NVM];
  assign read_go   = frame_ok && !frame[`TCC_F_WR];
  assign prog_done = (state == LK_PROG) && (prog_cnt == '0);

  // Frame bits arrive on supply-pin clock rises
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      shreg <= '0;
    end else if (rise && state == LK_SHIFT) begin
      shreg <= frame[22:0];
    end
  end

  // Quiet link resynchronises the bit counter
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      idle_cnt <= '0;
    end else if (rise || idle_to) begin
      idle_cnt <= '0;
    end else begin
      idle_cnt <= idle_cnt + 12'h001;
    end
  end

  // Link sequencer
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      state   <= LK_SHIFT;
      bit_cnt <= '0;
    end else begin
      case (state)
        LK_SHIFT: begin
          if (idle_to) begin
            bit_cnt <= '0;
          end else if (rise) begin
            bit_cnt <= frame_end ? 5'h00 : bit_cnt + 5'h01;
            if (prog_go) begin
              state <= LK_PROG;
            end else if (read_go) begin
              state <= LK_REPLY;
            end
          end
        end
        LK_REPLY: begin
          if (idle_to) begin
            bit_cnt <= '0;
            state   <= LK_SHIFT;
          end else if (rise) begin
            if (bit_cnt == `TCC_R_LAST) begin
              bit_cnt <= '0;
              state   <= LK_SHIFT;
            end else begin
              bit_cnt <= bit_cnt + 5'h01;
            end
          end
        end
        LK_PROG: begin
          if (prog_done) begin
            state <= LK_SHIFT;
          end
        end
        default: begin
          state   <= LK_SHIFT;
          bit_cnt <= '0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Read back
  // ----------------------------------------
  logic [15:0] rd_data;
  tcc_hall_t   hall_cap;

  // Raw array lines let the programmer rebuild parity
  always_comb begin
    rd_data = 16'h0000;
    if (addr < `TCC_A_NVM) begin
      rd_data = {6'h00, ram[addr[3:0]]};
    end else if (addr < `TCC_A_HALL) begin
      rd_data = {6'h00, nvm[addr[3:0]]};
    end else if (addr == `TCC_A_HALL) begin
      rd_data = hall_cap;
    end else if (addr == `TCC_A_STATUS) begin
      rd_data = {12'h000, corrected, uncorr, locked, prog_busy_out};
    end
  end

  // Reply goes out MSB first, one bit per rise
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      reply <= '0;
    end else if (read_go) begin
      reply <= rd_data;
    end else if (rise && state == LK_REPLY) begin
      reply <= {reply[14:0], 1'b0};
    end
  end

  assign link_pin_out    = reply[15];
  assign link_pin_oe_out = (state == LK_REPLY);

  // Last converter sample kept for readout
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      hall_cap <= '0;
    end else if (hall_valid_in) begin
      hall_cap <= hall_in;
    end
  end

  // ----------------------------------------
  // Storage updates
  // ----------------------------------------
  // Program time covers erase plus write pulse
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      prog_cnt <= '0;
    end else if (prog_go) begin
      prog_cnt <= `TCC_PROG_W'(PROG_CYC - 1);
    end else if (state == LK_PROG && prog_cnt != '0) begin
      prog_cnt <= prog_cnt - `TCC_PROG_W'(1);
    end
  end

  // Array changes only at the end of a program cycle
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      nvm <= `TCC_NVM_BLANK;
    end else if (prog_done) begin
      nvm <= ram;
    end
  end

  // Boot copy is corrected; later writes only touch RAM
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      boot <= 1'b1;
      ram  <= '0;
    end else begin
      boot <= 1'b0;
      if (boot) begin
        ram <= corr;
      end else if (wr_ram) begin
        ram[addr[3:0]] <= frame[`TCC_COLS-1:0];
      end
    end
  end

  assign locked_out    = locked;
  assign ecc_error_out = uncorr;
  assign prog_busy_out = (state == LK_PROG);

  // ----------------------------------------
  // Coefficient decode
  // ----------------------------------------
  logic signed [10:0] tc1;
  logic signed [9:0]  tc2;
  logic signed [10:0] t0;
  logic signed [35:0] tc1_x;
  logic signed [35:0] tc2_x;
  logic signed [35:0] dt_x;
  logic signed [35:0] sens;
  logic               test_mode;

  // User codes add to factory codes; linear and quadratic take the offset on each code, reference only on the factory code
  always_comb begin
    tc1 = $signed({2'b00, ram[`TCC_L_LIN][8:0]}) - `TCC_LIN_OFS
        + $signed({2'b00, ram[`TCC_L_LIN_F][8:0]}) - `TCC_LIN_OFS;
    tc2 = $signed({2'b00, ram[`TCC_L_QUAD][7:0]}) - `TCC_QUAD_OFS
        + $signed({2'b00, ram[`TCC_L_QUAD_F][7:0]}) - `TCC_QUAD_OFS;
    t0  = $signed({4'h0, ram[`TCC_L_REF_F][2:0], 4'h0}) - `TCC_REF_OFS
        + $signed({4'h0, ram[`TCC_L_REF][2:0], 4'h0});
  end

  assign test_mode = ram[`TCC_L_REF][`TCC_B_TEST];

  // ----------------------------------------
  // Sensitivity polynomial
  // ----------------------------------------
  // Fixed point with 23 fraction bits; no state, so repeatable
  always_comb begin
    tc1_x = 36'(tc1);
    tc2_x = 36'(tc2);
    dt_x  = 36'(temp_in);
    dt_x  = dt_x - 36'(t0);
    sens  = `TCC_ONE + ((tc1_x * dt_x) <<< `TCC_LIN_SHIFT) + tc2_x * dt_x * dt_x;
  end

  // ----------------------------------------
  // Hall scaling pipeline
  // ----------------------------------------
  logic signed [51:0] sens_q;
  logic signed [51:0] hall_q;
  logic signed [51:0] prod;
  logic               v1;

  // Stage one: factor and sample together
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      v1     <= 1'b0;
      sens_q <= '0;
      hall_q <= '0;
    end else begin
      v1 <= hall_valid_in;
      if (hall_valid_in) begin
        sens_q <= 52'(sens);
        hall_q <= 52'(hall_in);
      end
    end
  end

  assign prod = (hall_q * sens_q) >>> `TCC_FRAC;

  // Stage two: error clamp wins over test mode and scaling
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      comp_valid_out <= 1'b0;
      comp_out       <= '0;
    end else begin
      comp_valid_out <= v1;
      if (v1) begin
        if (uncorr) begin
          comp_out <= `TCC_ERR_CODE;
        end else if (test_mode) begin
          comp_out <= hall_q[15:0];
        end else if (prod > 52'(`TCC_ERR_CODE)) begin
          comp_out <= `TCC_ERR_CODE;
        end else if (prod < 52'(`TCC_SAT_LO)) begin
          comp_out <= `TCC_SAT_LO;
        end else begin
          comp_out <= prod[15:0];
        end
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_read_cmd;
    read_go;
  endsequence
  sequence s_reply_on;
    link_pin_oe_out [*8];
  endsequence
  property p_reply_drive;
    s_read_cmd |=> s_reply_on;
  endproperty
  a_reply_drive: assert property (p_reply_drive)
    else $error("Reply not driven after read frame");

  property p_lock_quiet;
    locked |-> !link_pin_oe_out;
  endproperty
  a_lock_quiet: assert property (p_lock_quiet)
    else $error("Frozen part drives the link");

  property p_lock_ram;
    locked && !boot |=> $stable(ram);
  endproperty
  a_lock_ram: assert property (p_lock_ram)
    else $error("RAM changed while frozen");

  property p_err_clamp;
    comp_valid_out && $past(uncorr) |-> comp_out == `TCC_ERR_CODE;
  endproperty
  a_err_clamp: assert property (p_err_clamp)
    else $error("Uncorrectable error not signalled");

  sequence s_sample;
    hall_valid_in;
  endsequence
  property p_latency;
    s_sample |-> ##2 comp_valid_out;
  endproperty
  a_latency: assert property (p_latency)
    else $error("Scaled sample late or missing");

  property p_test_mode;
    comp_valid_out && !$past(uncorr) && $past(test_mode) |-> comp_out == $past(hall_in, 2);
  endproperty
  a_test_mode: assert property (p_test_mode)
    else $error("Test mode output differs from sample");

  property p_boot_load;
    boot |=> ram == $past(corr);
  endproperty
  a_boot_load: assert property (p_boot_load)
    else $error("Boot copy not taken from corrected array");

  property p_row_odd;
    !uncorr |-> (^corr[`TCC_L_LIN]) && (^corr[`TCC_L_LOCK]);
  endproperty
  a_row_odd: assert property (p_row_odd)
    else $error("Corrected line has even parity");

  property p_nvm_hold;
    !prog_done |=> $stable(nvm);
  endproperty
  a_nvm_hold: assert property (p_nvm_hold)
    else $error("Array changed outside a program cycle");
endmodule

// *** dv/tcc_prog_model.sv ***
// Purpose: external programmer on the supply/output two-wire link
// Assumes: each supply-clock level held 4 system clocks for the 2-FF sync
// Notes:   a released data line shows the inverse of its last value
`timescale 1ns/1ps
module tcc_prog_model (
  input  wire logic clock_in,
  input  wire logic link_pin_out,
  input  wire logic link_pin_oe_out,
  output logic      vdd_clk_in,
  output logic      link_pin_in
);
  logic drv;

  // Wire level: the device wins while it drives the pin
  assign link_pin_in = link_pin_oe_out ? link_pin_out : drv;

  initial begin
    vdd_clk_in = 1'b0;
    drv        = 1'b0;
  end

  // One supply-clock period, data set up while the clock is low
  task automatic tick(input logic d);
    @(negedge clock_in);
    vdd_clk_in = 1'b0;
    drv        = d;
    repeat (4) @(negedge clock_in);
    vdd_clk_in = 1'b1;
    repeat (3) @(negedge clock_in);
  endtask

  // Whole frame MSB first; read frames clock 16 reply bits back
  task automatic xfer(input logic [23:0] f, input bit rd, output logic [15:0] r, output logic oe);
    r  = 16'h0;
    oe = 1'b0;
    for (int i = 23; i >= 0; i--) tick(f[i]);
    if (rd) begin
      for (int i = 15; i >= 0; i--) begin
        @(negedge clock_in);
        vdd_clk_in = 1'b0;
        drv        = ~drv;
        repeat (4) @(negedge clock_in);
        if (i == 15) oe = link_pin_oe_out;
        r[i]       = link_pin_out;
        vdd_clk_in = 1'b1;
        repeat (3) @(negedge clock_in);
      end
      repeat (8) @(negedge clock_in);
    end
    // Clock stands still between frames
    @(negedge clock_in);
    vdd_clk_in = 1'b0;
    drv        = ~drv;
  endtask
endmodule

// *** dv/temp_comp_cal_memory_tb.sv ***
// Purpose: self-checking bench of the compensation and calibration memory
// Assumes: short program cycle, blank array image after reset
// Notes:   expected samples come from a reference of the polynomial
`timescale 1ns/1ps
`include "tcc_consts.svh"
module temp_comp_cal_memory_tb;
  import tcc_pkg::*;
  localparam int PC = 20;
  logic       clock_in, rst_n_in, vdd_clk_in, link_pin_in, link_pin_out, link_pin_oe_out;
  logic       hall_valid_in, comp_valid_out, ecc_error_out, locked_out, prog_busy_out;
  tcc_temp_t  temp_in;
  tcc_hall_t  hall_in, comp_out;
  int         err_total, tests_run;
  logic [9:0] img [16];
  tcc_hall_t  expq [$];
  logic [2:0] vq;
  logic [15:0] rr;
  logic       ro;
  bit         err_exp;

  tcc_top #(.PROG_CYC(PC)) u_dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .vdd_clk_in(vdd_clk_in),
    .link_pin_in(link_pin_in), .link_pin_out(link_pin_out), .link_pin_oe_out(link_pin_oe_out),
    .temp_in(temp_in), .hall_in(hall_in), .hall_valid_in(hall_valid_in), .comp_out(comp_out),
    .comp_valid_out(comp_valid_out), .ecc_error_out(ecc_error_out), .locked_out(locked_out),
    .prog_busy_out(prog_busy_out));
  tcc_prog_model u_prog (.clock_in(clock_in), .link_pin_out(link_pin_out),
    .link_pin_oe_out(link_pin_oe_out), .vdd_clk_in(vdd_clk_in), .link_pin_in(link_pin_in));

  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end

  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic finish_test();
    if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Odd row parity in bit 9
  function automatic logic [9:0] rowp(input logic [8:0] d);
    return {~^d, d};
  endfunction

  // Column line: even columns total even, odd columns total odd
  task automatic fixcol();
    int n;
    for (int c = 0; c < 10; c++) begin
      n = 0;
      for (int l = 0; l < 15; l++) n += img[l][c];
      img[15][c] = (c % 2 == 0) ? n[0] : ~n[0];
    end
  endtask

  // Reference: error code, raw test mode, or scaled and saturated sample
  function automatic tcc_hall_t exp_comp(input tcc_hall_t h, input tcc_temp_t t);
    longint l1, l2, t0, dt, s, p;
    l1 = longint'(img[0][8:0]) - 160 + longint'(img[12][8:0]) - 160;
    l2 = longint'(img[1][7:0]) - 128 + longint'(img[13][7:0]) - 128;
    t0 = 16 * longint'(img[14][2:0]) - 48 + 16 * longint'(img[2][2:0]);
    dt = longint'(t) - t0;
    s  = (longint'(1) << 23) + l1 * dt * 128 + l2 * dt * dt;
    p  = (longint'(h) * s) >>> 23;
    if (err_exp) return 16'sh7fff;
    if (img[2][8]) return h;
    if (p > 32767) return 16'sh7fff;
    if (p < -32768) return 16'sh8000;
    return tcc_hall_t'(p);
  endfunction

  task automatic wr(input int n, input logic [9:0] v);
    img[n] = v;
    u_prog.xfer({2'b10, 6'(n), 6'h0, v}, 1'b0, rr, ro);
  endtask

  task automatic rd(input logic [5:0] a);
    u_prog.xfer({2'b00, a, 16'h0}, 1'b1, rr, ro);
  endtask

  // One program cycle, waited out on the busy flag
  task automatic prog();
    int n;
    u_prog.xfer({2'b11, 22'h0}, 1'b0, rr, ro);
    n = 0;
    while (prog_busy_out !== 1'b0 && n < PC + 50) begin
      @(negedge clock_in);
      n++;
    end
    chk("prog_done", 16'h1, 16'(n < PC + 50));
  endtask

  // Back-to-back samples, saturating corners first, repeats included
  task automatic samp(input int k);
    for (int i = 0; i < k; i++) begin
      @(negedge clock_in);
      if (i == 0) hall_in = 16'sh7fff;
      else if (i == 1) hall_in = 16'sh8000;
      else if (i % 4 != 3) begin
        hall_in = tcc_hall_t'($urandom);
        temp_in = 9'($urandom_range(190)) - 9'd40;
      end
      hall_valid_in = 1'b1;
      expq.push_back(exp_comp(hall_in, temp_in));
    end
    @(negedge clock_in);
    hall_valid_in = 1'b0;
    repeat (4) @(negedge clock_in);
  endtask

  // Answer timing and value of every sample
  always @(posedge clock_in) vq <= rst_n_in ? {vq[1:0], hall_valid_in} : 3'b0;
  always @(negedge clock_in) begin
    if (rst_n_in) begin
      chk("comp_valid", 16'(vq[1]), 16'(comp_valid_out));
      if (comp_valid_out === 1'b1 && expq.size() > 0) chk("comp_out", expq.pop_front(), comp_out);
    end
  end

  // Limit reckoned as about eight times the expected run
  initial begin
    #(25 * 60000);
    err_total++;
    finish_test();
  end

  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial begin
    err_total = 0;
    tests_run = 0;
    rst_n_in = 1'b0;
    hall_valid_in = 1'b0;
    hall_in = '0;
    temp_in = '0;
    vq = 3'b0;
    err_exp = 1'b0;
    void'($urandom(32'hd2a7));
    for (int i = 0; i < 15; i++) img[i] = 10'h200;
    img[15] = 10'h0aa;
    repeat (6) @(negedge clock_in);
    rst_n_in = 1'b1;
    repeat (4) @(negedge clock_in);
    rd(6'h21);
    chk("status", 16'h0, rr);
    chk("reply_oe_on", 16'h1, 16'(ro));
    rd(6'h0f);
    chk("ram_l15", 16'h00aa, rr);
    // Random user codes with parity recomputed
    wr(0, rowp(9'($urandom)));
    wr(1, rowp({1'b0, 8'($urandom)}));
    wr(2, rowp({6'h0, 3'($urandom)}));
    fixcol();
    wr(15, img[15]);
    for (int n = 0; n < 3; n++) begin
      rd(6'(n));
      chk("ram_line", {6'h0, img[n]}, rr);
    end
    rd(6'h10);
    chk("nvm_line0", 16'h0200, rr);
    samp(40);
    // Converter test mode passes raw samples
    wr(2, rowp({1'b1, img[2][7:0]}));
    samp(8);
    rd(6'h20);
    chk("last_hall", hall_in, rr);
    wr(2, rowp({1'b0, img[2][7:0]}));
    fixcol();
    wr(15, img[15]);
    // Single flipped bit is corrected
    wr(3, img[3] ^ 10'h001);
    prog();
    rd(6'h21);
    chk("status_fix", 16'h0008, rr);
    rd(6'h13);
    chk("nvm_line3", 16'h0201, rr);
    samp(8);
    // Second bad line cannot be corrected
    wr(4, img[4] ^ 10'h002);
    prog();
    err_exp = 1'b1;
    chk("ecc_error", 16'h1, 16'(ecc_error_out));
    rd(6'h21);
    chk("status_bad", 16'h0004, rr);
    samp(6);
    // Clean image with both freeze bits
    wr(3, img[3] ^ 10'h001);
    wr(4, img[4] ^ 10'h002);
    wr(14, rowp({2'b11, img[14][6:0]}));
    fixcol();
    wr(15, img[15]);
    prog();
    err_exp = 1'b0;
    chk("locked", 16'h1, 16'(locked_out));
    chk("ecc_clean", 16'h0, 16'(ecc_error_out));
    rd(6'h21);
    chk("reply_oe", 16'h0, 16'(ro));
    u_prog.xfer({2'b10, 6'h0, 6'h0, ~img[0]}, 1'b0, rr, ro);
    u_prog.xfer({2'b11, 22'h0}, 1'b0, rr, ro);
    chk("busy_locked", 16'h0, 16'(prog_busy_out));
    samp(8);
    finish_test();
  end
endmodule
